// [hdl/tld_device.sv]
// Purpose: Direction control of shared trigger, star and neighbour lines, APB slave.
// Assumes: Lines are static or slow pulses; inputs pass two flip-flops.
// Notes: Load inhibit strap is caught once both synchroniser flops hold a real sample.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tld_device (
  input wire logic pclk, // Clock, 100 MHz.
  input wire logic presetn, // Async reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error, unmapped address.
  input wire logic load_inhibit_sw, // Load inhibit switch level.
  output logic load_start, // One-cycle pulse, start stored design load.
  tld_link_if.device link // Shared lines.
);
  import tld_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TLD_TRIG_W-1:0] t_dir;
    logic [TLD_TRIG_W-1:0] t_out;
    logic [TLD_TRIG_W-1:0] t_s1;
    logic [TLD_TRIG_W-1:0] t_s2;
    logic s_dir;
    logic s_out;
    logic s_s1;
    logic s_s2;
    logic [TLD_NB_W-1:0] l_dir;
    logic [TLD_NB_W-1:0] l_out;
    logic [TLD_NB_W-1:0] l_s1;
    logic [TLD_NB_W-1:0] l_s2;
    logic [TLD_NB_W-1:0] r_dir;
    logic [TLD_NB_W-1:0] r_out;
    logic [TLD_NB_W-1:0] r_s1;
    logic [TLD_NB_W-1:0] r_s2;
    logic inh_s1;
    logic inh_s2;
    logic fill1;
    logic fill2;
    logic strapped;
    logic inhibit;
    logic autoload;
    logic done;
    logic start;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } tld_dev_t;
  tld_dev_t st_reg, st_next;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Used only for the error answer; the read mux decodes paddr in its own case statement.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= TLD_OFF_IN_RIGHT) && (a[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic acc;
  always_comb begin
    st_next = st_reg;
    acc = psel && !penable;
    if (ce) begin
      st_next.start = 1'b0;

      // ------------------------------------------------------------
      // Input synchronisers
      // ------------------------------------------------------------
      st_next.t_s1 = link.trig_i;
      st_next.t_s2 = st_reg.t_s1;
      st_next.s_s1 = link.star_i;
      st_next.s_s2 = st_reg.s_s1;
      st_next.l_s1 = link.left_i;
      st_next.l_s2 = st_reg.l_s1;
      st_next.r_s1 = link.right_i;
      st_next.r_s2 = st_reg.r_s1;
      st_next.inh_s1 = load_inhibit_sw;
      st_next.inh_s2 = st_reg.inh_s1;
      st_next.fill1 = 1'b1;
      st_next.fill2 = st_reg.fill1;

      // ------------------------------------------------------------
      // Strap capture and load start
      // ------------------------------------------------------------
      // The strap is caught once, from the second flop only, after both flops took a
      // real sample: their reset zeros would otherwise read as permission to load.
      if (!st_reg.strapped && st_reg.fill2) begin
        st_next.strapped = 1'b1;
        st_next.inhibit = st_reg.inh_s2;
      end
      // Load fires once, only if permitted by switch and software.
      if (st_reg.strapped && !st_reg.inhibit && st_reg.autoload && !st_reg.done) begin
        st_next.start = 1'b1;
        st_next.done = 1'b1;
      end

      // ------------------------------------------------------------
      // Register read
      // ------------------------------------------------------------
      // Setup is answered one cycle later; read data stands while ready is high.
      st_next.ready = 1'b0;
      st_next.err = 1'b0;
      if (acc) begin
        st_next.ready = 1'b1;
        st_next.err = !mapped(paddr);
        st_next.rdata = TLD_RESET_VAL;
        if (!pwrite) begin
          unique case (paddr)
            TLD_OFF_TRIG_DIR: st_next.rdata[TLD_TRIG_W-1:0] = st_reg.t_dir;
            TLD_OFF_TRIG_OUT: st_next.rdata[TLD_TRIG_W-1:0] = st_reg.t_out;
            TLD_OFF_STAR: begin
              st_next.rdata[TLD_STAR_DIR_BIT] = st_reg.s_dir;
              st_next.rdata[TLD_STAR_OUT_BIT] = st_reg.s_out;
              st_next.rdata[TLD_STAR_IN_BIT] = st_reg.s_s2;
            end
            TLD_OFF_LEFT_DIR: st_next.rdata[TLD_NB_W-1:0] = st_reg.l_dir;
            TLD_OFF_LEFT_OUT: st_next.rdata[TLD_NB_W-1:0] = st_reg.l_out;
            TLD_OFF_RIGHT_DIR: st_next.rdata[TLD_NB_W-1:0] = st_reg.r_dir;
            TLD_OFF_RIGHT_OUT: st_next.rdata[TLD_NB_W-1:0] = st_reg.r_out;
            TLD_OFF_LOAD: begin
              st_next.rdata[TLD_LOAD_AUTO_BIT] = st_reg.autoload;
              st_next.rdata[TLD_LOAD_INH_BIT] = st_reg.inhibit;
              st_next.rdata[TLD_LOAD_DONE_BIT] = st_reg.done;
              st_next.rdata[TLD_LOAD_UNCAL_BIT] = st_reg.inhibit;
            end
            TLD_OFF_IN_TRIG: st_next.rdata[TLD_TRIG_W-1:0] = st_reg.t_s2;
            TLD_OFF_IN_LEFT: st_next.rdata[TLD_NB_W-1:0] = st_reg.l_s2;
            TLD_OFF_IN_RIGHT: st_next.rdata[TLD_NB_W-1:0] = st_reg.r_s2;
            default: st_next.rdata = TLD_RESET_VAL;
          endcase
        end
      end

      // ------------------------------------------------------------
      // Register write
      // ------------------------------------------------------------
      // A write lands only at the access edge at which the master samples ready high,
      // so a line never turns before the transfer that ordered it has completed.
      // Writes are accepted whether or not loading was inhibited.
      // Writes to the read-only input and status words are ignored without error.
      if (psel && penable && pwrite && st_reg.ready) begin
        unique case (paddr)
          TLD_OFF_TRIG_DIR: st_next.t_dir = pwdata[TLD_TRIG_W-1:0];
          TLD_OFF_TRIG_OUT: st_next.t_out = pwdata[TLD_TRIG_W-1:0];
          TLD_OFF_STAR: begin
            st_next.s_dir = pwdata[TLD_STAR_DIR_BIT];
            st_next.s_out = pwdata[TLD_STAR_OUT_BIT];
          end
          TLD_OFF_LEFT_DIR: st_next.l_dir = pwdata[TLD_NB_W-1:0];
          TLD_OFF_LEFT_OUT: st_next.l_out = pwdata[TLD_NB_W-1:0];
          TLD_OFF_RIGHT_DIR: st_next.r_dir = pwdata[TLD_NB_W-1:0];
          TLD_OFF_RIGHT_OUT: st_next.r_out = pwdata[TLD_NB_W-1:0];
          TLD_OFF_LOAD: st_next.autoload = pwdata[TLD_LOAD_AUTO_BIT];
          default: st_next.err = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Direction bits drive the enables directly; software owns contention avoidance.
  // A direction change shows at the same edge at which the write lands, never earlier.
  assign link.dev_trig_oe = st_reg.t_dir;
  assign link.dev_trig_o = st_reg.t_out;
  assign link.dev_star_oe = st_reg.s_dir;
  assign link.dev_star_o = st_reg.s_out;
  assign link.dev_left_oe = st_reg.l_dir;
  assign link.dev_left_o = st_reg.l_out;
  assign link.dev_right_oe = st_reg.r_dir;
  assign link.dev_right_o = st_reg.r_out;
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign load_start = st_reg.start;
endmodule
`default_nettype wire

// [hdl/tld_far_end.sv]
// Purpose: Neighbour slot end sharing the trigger lines with the device.
// Assumes: Its right lines face the device's left lines.
// Notes: It never drives a line the device currently drives.
`timescale 1ns/1ps
`default_nettype none
module tld_far_end (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Async reset, active low.
  input wire logic ce, // Clock enable.
  tld_link_if.far link, // Shared lines.
  input wire logic [tld_pkg::TLD_TRIG_W-1:0] want_trig_oe, // Trigger drive request.
  input wire logic [tld_pkg::TLD_TRIG_W-1:0] want_trig_val, // Trigger drive value.
  input wire logic want_star_oe, // Star drive request.
  input wire logic want_star_val, // Star drive value.
  input wire logic [tld_pkg::TLD_NB_W-1:0] want_nb_oe, // Neighbour drive request.
  input wire logic [tld_pkg::TLD_NB_W-1:0] want_nb_val, // Neighbour drive value.
  input wire logic [tld_pkg::TLD_TRIG_W-1:0] dev_trig_oe, // Device trigger enables.
  input wire logic dev_star_oe, // Device star enable.
  input wire logic [tld_pkg::TLD_NB_W-1:0] dev_nb_oe, // Device left enables.
  output logic [tld_pkg::TLD_TRIG_W-1:0] trig_seen, // Synchronised trigger levels.
  output logic star_seen, // Synchronised star level.
  output logic [tld_pkg::TLD_NB_W-1:0] nb_seen // Synchronised neighbour levels.
);
  import tld_pkg::*;
  typedef struct packed {
    logic [TLD_TRIG_W-1:0] t_oe, t_o, t_s1, t_s2;
    logic s_oe, s_o, s_s1, s_s2;
    logic [TLD_NB_W-1:0] n_oe, n_o, n_s1, n_s2;
  } tld_far_t;
  tld_far_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.t_oe = want_trig_oe & ~dev_trig_oe;
      st_next.t_o = want_trig_val;
      st_next.s_oe = want_star_oe & ~dev_star_oe;
      st_next.s_o = want_star_val;
      st_next.n_oe = want_nb_oe & ~dev_nb_oe;
      st_next.n_o = want_nb_val;
      st_next.t_s1 = link.trig_i;
      st_next.t_s2 = st_reg.t_s1;
      st_next.s_s1 = link.star_i;
      st_next.s_s2 = st_reg.s_s1;
      st_next.n_s1 = link.left_i;
      st_next.n_s2 = st_reg.n_s1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign link.far_trig_o = st_reg.t_o;
  // The registered request lags the device by one edge, so the enables are also masked
  // at once; otherwise both ends would drive a line for the cycle after a turn.
  assign link.far_trig_oe = st_reg.t_oe & ~dev_trig_oe;
  assign link.far_star_o = st_reg.s_o;
  assign link.far_star_oe = st_reg.s_oe & ~dev_star_oe;
  assign link.far_left_o = st_reg.n_o;
  assign link.far_left_oe = st_reg.n_oe & ~dev_nb_oe;
  assign trig_seen = st_reg.t_s2;
  assign star_seen = st_reg.s_s2;
  assign nb_seen = st_reg.n_s2;
endmodule
`default_nettype wire

// [hdl/tld_link_if.sv]
// Purpose: Pins shared between the device end and another slot's end.
// Assumes: The bench resolves wires from the enables.
// Notes: Enables are high while the owner drives the line.
`timescale 1ns/1ps
`default_nettype none
interface tld_link_if;
  import tld_pkg::*;
  logic [TLD_TRIG_W-1:0] dev_trig_o, dev_trig_oe, trig_i;
  logic dev_star_o, dev_star_oe, star_i;
  logic [TLD_NB_W-1:0] dev_left_o, dev_left_oe, left_i;
  logic [TLD_NB_W-1:0] dev_right_o, dev_right_oe, right_i;
  logic [TLD_TRIG_W-1:0] far_trig_o, far_trig_oe;
  logic far_star_o, far_star_oe;
  logic [TLD_NB_W-1:0] far_left_o, far_left_oe;
  modport device (output dev_trig_o, dev_trig_oe, dev_star_o, dev_star_oe, dev_left_o,
    dev_left_oe, dev_right_o, dev_right_oe, input trig_i, star_i, left_i, right_i);
  modport far (output far_trig_o, far_trig_oe, far_star_o, far_star_oe, far_left_o,
    far_left_oe, input trig_i, star_i, left_i);
endinterface
`default_nettype wire

// [hdl/tld_pkg.sv]
// Purpose: Shared constants for the trigger line direction control block.
// Assumes: One 100 MHz clock, APB register access, 32-bit data.
// Notes: Offsets are byte addresses of aligned words.
package tld_pkg;
  localparam int TLD_TRIG_W = 8;
  localparam int TLD_NB_W = 13;
  localparam logic [11:0] TLD_OFF_TRIG_DIR = 12'h000;
  localparam logic [11:0] TLD_OFF_TRIG_OUT = 12'h004;
  localparam logic [11:0] TLD_OFF_STAR = 12'h008;
  localparam logic [11:0] TLD_OFF_LEFT_DIR = 12'h00C;
  localparam logic [11:0] TLD_OFF_LEFT_OUT = 12'h010;
  localparam logic [11:0] TLD_OFF_RIGHT_DIR = 12'h014;
  localparam logic [11:0] TLD_OFF_RIGHT_OUT = 12'h018;
  localparam logic [11:0] TLD_OFF_LOAD = 12'h01C;
  localparam logic [11:0] TLD_OFF_IN_TRIG = 12'h020;
  localparam logic [11:0] TLD_OFF_IN_LEFT = 12'h024;
  localparam logic [11:0] TLD_OFF_IN_RIGHT = 12'h028;
  localparam int TLD_STAR_DIR_BIT = 0;
  localparam int TLD_STAR_OUT_BIT = 1;
  localparam int TLD_STAR_IN_BIT = 2;
  localparam int TLD_LOAD_AUTO_BIT = 0;
  localparam int TLD_LOAD_INH_BIT = 1;
  localparam int TLD_LOAD_DONE_BIT = 2;
  localparam int TLD_LOAD_UNCAL_BIT = 3;
  localparam logic [31:0] TLD_RESET_VAL = 32'h0000_0000;
endpackage

// [verif/tb.sv]
// Purpose: Self-checking bench joining device end and far end.
// Assumes: Undriven trigger, star and left lines toggle, so only driven bits are compared there; released right lines read rdrv.
// Notes: Far end yields to the device on every shared line.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tld_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sw = 0, idle = 0;
  logic w_star = 1, pready, pslverr, load_start, er, star_seen;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] wt_oe = 8'hF0, wt_v = 8'hA0, trig_seen;
  logic [12:0] wn_oe = 13'h1FFF, wn_v = 13'h15AA, rdrv = 13'h0ABC, nb_seen;
  int mismatches = 0, n_checks = 0, n_load = 0;
  tld_link_if link ();
  tld_device tld_device_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .load_inhibit_sw(sw), .load_start(load_start),
    .link(link.device));
  tld_far_end tld_far_end_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .link(link.far),
    .want_trig_oe(wt_oe), .want_trig_val(wt_v), .want_star_oe(w_star), .want_star_val(1'b1),
    .want_nb_oe(wn_oe), .want_nb_val(wn_v), .dev_trig_oe(link.dev_trig_oe),
    .dev_star_oe(link.dev_star_oe), .dev_nb_oe(link.dev_left_oe), .trig_seen(trig_seen),
    .star_seen(star_seen), .nb_seen(nb_seen));
  tld_link_asserts tld_link_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .load_inhibit_sw(sw), .load_start(load_start), .dev_trig_oe(link.dev_trig_oe),
    .far_trig_oe(link.far_trig_oe), .dev_star_oe(link.dev_star_oe),
    .far_star_oe(link.far_star_oe), .dev_left_oe(link.dev_left_oe),
    .far_left_oe(link.far_left_oe), .dev_right_oe(link.dev_right_oe));
  // ----------------------------------------
  // Wire resolution and clock
  // ----------------------------------------
  // A released trigger, star or left line toggles so a stale value can never pass for a driven one; a released right line reads rdrv.
  assign link.trig_i = (link.dev_trig_oe & link.dev_trig_o) | (link.far_trig_oe & link.far_trig_o)
    | (~(link.dev_trig_oe | link.far_trig_oe) & {8{idle}});
  assign link.star_i = (link.dev_star_oe & link.dev_star_o) | (link.far_star_oe & link.far_star_o)
    | (~(link.dev_star_oe | link.far_star_oe) & idle);
  assign link.left_i = (link.dev_left_oe & link.dev_left_o) | (link.far_left_oe & link.far_left_o)
    | (~(link.dev_left_oe | link.far_left_oe) & {13{idle}});
  assign link.right_i = (link.dev_right_oe & link.dev_right_o) | (~link.dev_right_oe & rdrv);
  always #5 pclk = ~pclk;
  always @(posedge pclk) idle <= ~idle;
  always @(posedge pclk) if (load_start === 1'b1) n_load++;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, '0);
    cmp(nm, rd & m, e);
  endtask
  task automatic rst(input logic s);
    presetn <= 1'b0;
    sw <= s;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    n_load = 0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #200000;
    mismatches++;
    final_report;
  end
  initial begin
    rst(1'b0);
    cmp("oe_reset", 32'({link.dev_trig_oe, link.dev_star_oe, link.dev_left_oe}), '0);
    cmp("right_oe_reset", 32'(link.dev_right_oe), '0);
    rchk("dir_reset", TLD_OFF_TRIG_DIR, 32'hFFFF_FFFF, TLD_RESET_VAL);
    $display("test reset done");
    apb(1'b1, TLD_OFF_TRIG_OUT, 32'h0000_005A);
    apb(1'b1, TLD_OFF_TRIG_DIR, 32'h0000_003C);
    repeat (4) @(posedge pclk);
    cmp("trig_oe", 32'(link.dev_trig_oe), 32'h0000_003C);
    cmp("far_trig_oe", 32'(link.far_trig_oe), 32'h0000_00C0);
    cmp("trig_seen", 32'(trig_seen & 8'hFC), 32'h0000_0098);
    rchk("trig_in", TLD_OFF_IN_TRIG, 32'h0000_00FC, 32'h0000_0098);
    $display("test trigger done");
    rchk("star_in", TLD_OFF_STAR, 32'h0000_0004, 32'h0000_0004);
    apb(1'b1, TLD_OFF_STAR, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    cmp("far_star_oe", 32'(link.far_star_oe), '0);
    cmp("star_seen", 32'(star_seen), '0);
    $display("test star done");
    apb(1'b1, TLD_OFF_LEFT_OUT, 32'h0000_0033);
    apb(1'b1, TLD_OFF_LEFT_DIR, 32'h0000_00FF);
    apb(1'b1, TLD_OFF_RIGHT_OUT, 32'h0000_1FFF);
    apb(1'b1, TLD_OFF_RIGHT_DIR, 32'h0000_1000);
    repeat (4) @(posedge pclk);
    cmp("far_left_oe", 32'(link.far_left_oe), 32'h0000_1F00);
    cmp("nb_seen", 32'(nb_seen), 32'h0000_1533);
    rchk("left_in", TLD_OFF_IN_LEFT, 32'h0000_1FFF, 32'h0000_1533);
    rchk("right_in", TLD_OFF_IN_RIGHT, 32'h0000_1FFF, 32'h0000_1ABC);
    $display("test neighbour done");
    apb(1'b0, 12'h02C, '0);
    cmp("unmapped_err", 32'(er), 32'h0000_0001);
    apb(1'b0, 12'h002, '0);
    cmp("unaligned_err", 32'(er), 32'h0000_0001);
    $display("test error done");
    cmp("no_autoload", 32'(n_load), '0);
    apb(1'b1, TLD_OFF_LOAD, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    cmp("autoload", 32'(n_load), 32'h0000_0001);
    rchk("load_flags", TLD_OFF_LOAD, 32'h0000_000B, 32'h0000_0001);
    rst(1'b1);
    apb(1'b1, TLD_OFF_LOAD, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    cmp("inhibit_load", 32'(n_load), '0);
    rchk("inhibit_flags", TLD_OFF_LOAD, 32'h0000_000B, 32'h0000_000B);
    apb(1'b1, TLD_OFF_TRIG_DIR, 32'h0000_0081);
    rchk("cfg_inhibited", TLD_OFF_TRIG_DIR, 32'h0000_00FF, 32'h0000_0081);
    $display("test load done");
    final_report;
  end
endmodule
`default_nettype wire

// [verif/tld_link_asserts.sv]
// Purpose: Concurrent checks on the shared lines and the register port.
// Assumes: Clock enable held high; one clock domain.
// Notes: Instantiated by the bench beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module tld_link_asserts (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Async reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic load_inhibit_sw, // Load inhibit switch.
  input wire logic load_start, // Load start pulse.
  input wire logic [tld_pkg::TLD_TRIG_W-1:0] dev_trig_oe, // Device trigger enables.
  input wire logic [tld_pkg::TLD_TRIG_W-1:0] far_trig_oe, // Far trigger enables.
  input wire logic dev_star_oe, // Device star enable.
  input wire logic far_star_oe, // Far star enable.
  input wire logic [tld_pkg::TLD_NB_W-1:0] dev_left_oe, // Device left enables.
  input wire logic [tld_pkg::TLD_NB_W-1:0] far_left_oe, // Far enables facing them.
  input wire logic [tld_pkg::TLD_NB_W-1:0] dev_right_oe // Device right enables.
);
  import tld_pkg::*;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_trig_one_driver: assert property ((dev_trig_oe & far_trig_oe) == '0)
    else $error("trigger line driven by both ends");
  chk_star_one_driver: assert property (dev_star_oe |-> !far_star_oe)
    else $error("star line driven by both ends");
  chk_nb_one_driver: assert property ((dev_left_oe & far_left_oe) == '0)
    else $error("neighbour line driven by both ends");
  // Enables may only move because software wrote a register.
  chk_dir_by_write: assert property (!$stable({dev_trig_oe, dev_star_oe, dev_left_oe,
    dev_right_oe}) |-> $past(psel && penable && pwrite))
    else $error("line direction changed without a write");
  chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_load_gated: assert property (load_start |-> !load_inhibit_sw)
    else $error("load started while inhibited");
  chk_load_once: assert property (load_start |=> !load_start)
    else $error("load start longer than one cycle");
endmodule
`default_nettype wire
